// ===== src/asr_space.sv
// Program memory map and register file of the 8-bit core's address space.
// Assumes the core drives fetch and register requests synchronously.
`timescale 1ns/1ps
`default_nettype none
module asr_space
    import asr_pkg::*;
#(
    parameter int PM_BYTES = 16384
)(
    input  wire logic                  mclk,
    input  wire logic                  rstn,
    // Fetch side
    input  wire logic                  pc_step,
    input  wire logic                  pc_load,
    input  wire logic [PM_AW-1:0]      pc_target,
    input  wire logic                  irq_take,
    input  wire logic                  data_rd,
    input  wire logic [PM_AW-1:0]      data_addr,
    output logic      [PM_AW-1:0]      pm_addr,
    output logic                       pm_valid,
    output logic                       pm_vec,
    input  wire logic [7:0]            pm_rdata,
    output logic                       rc_osc_sel,
    output logic                       opt_valid,
    // Register side
    input  wire logic                  rf_req,
    input  wire logic                  rf_we,
    input  wire logic                  rf_pair,
    input  wire logic                  rf_wr_mode,
    input  wire logic [3:0]            rf_wreg,
    input  wire logic [RB_W-1:0]       rf_addr,
    input  wire logic [15:0]           rf_wdata,
    input  wire logic                  page1,
    output logic      [15:0]           rf_rdata,
    output logic                       rf_ack,
    output logic                       rf_bad_mode
);
    import asr_pkg::*;

    // Clipping by mask only works for a power-of-two array
    if (PM_BYTES < 512 || PM_BYTES > (1 << PM_AW)
        || (PM_BYTES & (PM_BYTES - 1)) != 0) begin : g_size_check
        $error("PM_BYTES out of range");
    end

    typedef enum logic [1:0] {
        ASR_BOOT_OPT,
        ASR_BOOT_WAIT,
        ASR_RUN
    } asr_boot_t;

    asr_boot_t         boot_q;
    logic [PM_AW-1:0]  pm_addr_q;
    logic              pm_valid_q;
    logic              pm_vec_q;
    logic              vec_hi_q;
    logic              rc_q;
    logic              optv_q;
    logic [PM_AW-1:0]  pc_q;

    // Clip to physical size so strays never alias outside the array
    function automatic logic [PM_AW-1:0] pm_clip(input logic [PM_AW-1:0] a);
        pm_clip = a & PM_AW'(PM_BYTES - 1);
    endfunction

    wire               in_run    = (boot_q == ASR_RUN);
    wire               vec_start = in_run && irq_take && !vec_hi_q;
    wire [PM_AW-1:0]   pc_next   = pc_load ? pc_target
                                           : PM_AW'(pc_q + 16'h0001);
    wire [PM_AW-1:0]   fetch_a   =
        vec_start ? PM_VEC_LO :
        vec_hi_q  ? PM_VEC_HI :
        data_rd   ? pm_clip(data_addr) : pm_clip(pc_q);
    wire               fetch_go  = in_run && (vec_start || vec_hi_q
                                   || data_rd || pc_step || pc_load);

    // Option byte is read once after reset before any fetch
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            boot_q <= ASR_BOOT_OPT;
            rc_q   <= 1'b0;
            optv_q <= 1'b0;
        end else begin
            unique case (boot_q)
                ASR_BOOT_OPT: boot_q <= ASR_BOOT_WAIT;
                ASR_BOOT_WAIT: begin
                    boot_q <= ASR_RUN;
                    rc_q   <= (pm_rdata == OPT_RC_OSC);
                    optv_q <= 1'b1;
                end
                ASR_RUN: boot_q <= ASR_RUN;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pc_q       <= PM_RESET_PC;
            pm_addr_q  <= PM_OPT_USED;
            pm_valid_q <= 1'b0;
            pm_vec_q   <= 1'b0;
            vec_hi_q   <= 1'b0;
        end else begin
            pm_addr_q  <= in_run ? fetch_a : PM_OPT_USED;
            pm_valid_q <= fetch_go || (boot_q == ASR_BOOT_OPT);
            pm_vec_q   <= vec_start || vec_hi_q;
            vec_hi_q   <= vec_start;
            if (in_run && !vec_start && !vec_hi_q && (pc_step || pc_load))
                pc_q <= pc_next;
        end
    end

    assign pm_addr    = pm_addr_q;
    assign pm_valid   = pm_valid_q;
    assign pm_vec     = pm_vec_q;
    assign rc_osc_sel = rc_q;
    assign opt_valid  = optv_q;

    // Register file storage: 176 + 192 general bytes, 64 control bytes
    logic [7:0] gp_mem   [GP_P0_BYTES + GP_P1_BYTES];
    logic [7:0] ctrl_mem [CTRL_BYTES];

    // Working mode always maps into the common window
    wire [7:0] eff_addr = rf_wr_mode ? (RF_COMMON_BASE | {4'h0, rf_wreg})
                                     : rf_addr;
    wire [7:0] addr_hi  = eff_addr & 8'hfe;
    wire [7:0] addr_lo  = eff_addr | 8'h01;
    wire [7:0] a0       = rf_pair ? addr_hi : eff_addr;

    asr_region_t rg0, rg1;
    logic        imp0, imp1;
    logic [8:0]  gi0, gi1;
    logic [5:0]  ci0, ci1;

    asr_decode u_dec0 (
        .addr       (a0),
        .page1      (page1),
        .region     (rg0),
        .impl       (imp0),
        .gp_index   (gi0),
        .ctrl_index (ci0)
    );
    asr_decode u_dec1 (
        .addr       (addr_lo),
        .page1      (page1),
        .region     (rg1),
        .impl       (imp1),
        .gp_index   (gi1),
        .ctrl_index (ci1)
    );

    // Full address into common window flagged, but still served
    wire bad_mode = rf_req && !rf_wr_mode && (rg0 == ASR_RG_COMMON);

    function automatic logic [7:0] rf_byte(input asr_region_t rg,
                                           input logic imp,
                                           input logic [8:0] gi,
                                           input logic [5:0] ci);
        if (!imp)
            rf_byte = UNDEF_READ;
        else if (rg == ASR_RG_GP)
            rf_byte = gp_mem[gi];
        else
            rf_byte = ctrl_mem[ci];
    endfunction

    wire [7:0] b0 = rf_byte(rg0, imp0, gi0, ci0);
    wire [7:0] b1 = rf_byte(rg1, imp1, gi1, ci1);
    wire [15:0] rd_word = rf_pair ? {b0, b1} : {8'h00, b0};
    wire [7:0]  wr_b0   = rf_pair ? rf_wdata[15:8] : rf_wdata[7:0];
    wire [7:0]  wr_b1   = rf_wdata[7:0];

    // Storage has no reset; contents are undefined until written
    always_ff @(posedge mclk) begin
        if (rf_req && rf_we && imp0) begin
            if (rg0 == ASR_RG_GP)
                gp_mem[gi0] <= wr_b0;
            else
                ctrl_mem[ci0] <= wr_b0;
        end
        if (rf_req && rf_we && rf_pair && imp1) begin
            if (rg1 == ASR_RG_GP)
                gp_mem[gi1] <= wr_b1;
            else
                ctrl_mem[ci1] <= wr_b1;
        end
    end

    logic [15:0] rd_q;
    logic        ack_q;
    logic        bad_q;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rd_q  <= 16'h0000;
            ack_q <= 1'b0;
            bad_q <= 1'b0;
        end else begin
            ack_q <= rf_req;
            bad_q <= bad_mode;
            if (rf_req && !rf_we)
                rd_q <= rd_word;
        end
    end

    assign rf_rdata    = rd_q;
    assign rf_ack      = ack_q;
    assign rf_bad_mode = bad_q;

    // All properties share one clock; none are checked in reset
    default clocking asr_cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    AST_RESET_PC: assert property (
        (boot_q != ASR_RUN) |-> (pc_q == PM_RESET_PC))
        else $error("PC left reset entry before run");
    AST_VEC_PAIR: assert property (
        vec_start |=> ((pm_addr == PM_VEC_LO) && pm_vec)
                      ##1 ((pm_addr == PM_VEC_HI) && pm_vec))
        else $error("Vector fetch not 0000h then 0001h");
    AST_PM_RANGE: assert property (
        pm_valid |-> (pm_addr <= PM_LAST))
        else $error("Program address beyond 3FFFh");
    AST_OPT_ADDR: assert property (
        (boot_q == ASR_BOOT_WAIT) |-> (pm_addr == PM_OPT_USED) && pm_valid)
        else $error("Option fetch not at 003Fh");
    AST_RC_SEL: assert property (
        (boot_q == ASR_BOOT_WAIT)
        |=> (rc_osc_sel == $past(pm_rdata == OPT_RC_OSC)) && opt_valid)
        else $error("RC select does not follow option byte");
    AST_BLANK_OPT: assert property (
        (boot_q == ASR_BOOT_WAIT && pm_rdata == OPT_BLANK) |=> !rc_osc_sel)
        else $error("Blank option selected RC oscillator");
    AST_ACK: assert property (
        rf_req |=> rf_ack)
        else $error("Register request not acknowledged");
    AST_PAIR_HI: assert property (
        (rf_req && rf_pair && !rf_wr_mode)
        |-> (a0 == {rf_addr[7:1], 1'b0}) && (addr_lo == {rf_addr[7:1], 1'b1}))
        else $error("Pair address not even then odd");
    AST_UNDEF: assert property (
        (rf_req && !rf_we && !rf_pair && !imp0)
        |=> (rf_rdata == {8'h00, UNDEF_READ}))
        else $error("Unimplemented read not undefined value");
    AST_GP_LOW: assert property (
        (rf_req && (a0 <= RF_GP_LAST)) |-> (rg0 == ASR_RG_GP) && imp0)
        else $error("00h-AFh not general space");
    AST_COMMON: assert property (
        (rf_req && rg0 == ASR_RG_COMMON) |-> (ci0 == {2'b00, a0[3:0]}))
        else $error("Common area depends on page");
    AST_BAD: assert property (
        (rf_req && !rf_wr_mode && a0 >= RF_COMMON_BASE
         && a0 <= RF_COMMON_LAST) |=> rf_bad_mode)
        else $error("Full address in common window not flagged");
    AST_PC_STEP: assert property (
        (in_run && pc_step && !pc_load && !vec_start && !vec_hi_q)
        |=> (pc_q == $past(pc_q) + 16'h0001))
        else $error("PC did not advance by one");
    AST_PC_LOAD: assert property (
        (in_run && pc_load && !vec_start && !vec_hi_q)
        |=> (pc_q == $past(pc_target)))
        else $error("PC did not take the load target");
    AST_PC_FETCH: assert property (
        (in_run && pc_step && !pc_load && !data_rd && !vec_start
         && !vec_hi_q && (pc_q <= PM_LAST))
        |=> pm_valid && (pm_addr == $past(pc_q)))
        else $error("Fetch address is not the PC");
    AST_DATA_RD: assert property (
        (in_run && data_rd && !vec_start && !vec_hi_q
         && (data_addr <= PM_LAST))
        |=> pm_valid && (pm_addr == $past(data_addr)))
        else $error("Table read address not presented");
    AST_BOOT_HOLD: assert property (
        (boot_q != ASR_RUN) |=> (pm_addr == PM_OPT_USED) && !pm_vec)
        else $error("Fetch left option byte during boot");
    AST_VEC_PC_HOLD: assert property (
        (vec_start || vec_hi_q) |=> (pc_q == $past(pc_q)))
        else $error("PC moved during vector fetch");
    AST_ACK_ONCE: assert property (
        rf_ack |-> $past(rf_req))
        else $error("Acknowledge without a request");
    AST_WR_MODE: assert property (
        (rf_req && rf_wr_mode && !rf_pair)
        |-> (rg0 == ASR_RG_COMMON) && (ci0 == {2'b00, rf_wreg}))
        else $error("Working register number not in common area");
    AST_PAGE_SPLIT: assert property (
        (rf_req && imp0 && (rg0 == ASR_RG_GP))
        |-> ((gi0 >= 9'(GP_P0_BYTES)) == page1))
        else $error("Page select does not pick the physical byte");
    AST_B0_UNIMPL: assert property (
        (rf_req && !page1 && (a0 > RF_GP_LAST) && (a0 < RF_COMMON_BASE))
        |-> !imp0)
        else $error("Page 0 B0h-BFh decoded as storage");
    AST_UPPER_CTRL: assert property (
        (rf_req && (a0 >= RF_CTRL_BASE)) |-> (rg0 != ASR_RG_GP) && imp0)
        else $error("Upper area decoded as general space");
    AST_RD_HOLD: assert property (
        !(rf_req && !rf_we) |=> $stable(rf_rdata))
        else $error("Read data changed without a read");
endmodule
`default_nettype wire

// ===== src/asr_pkg.sv
// Address-space constants for the core's program memory and register file.
// Assumes a single-clock core that issues fetch and register requests.
package asr_pkg;
    localparam int          PM_AW          = 16;
    localparam int          RB_W           = 8;
    localparam logic [15:0] PM_LAST        = 16'h3fff;
    localparam logic [15:0] PM_VEC_LO      = 16'h0000;
    localparam logic [15:0] PM_VEC_HI      = 16'h0001;
    localparam logic [15:0] PM_RESET_PC    = 16'h0100;
    localparam logic [15:0] PM_OPT_FIRST   = 16'h003c;
    localparam logic [15:0] PM_OPT_USED    = 16'h003f;
    localparam logic [7:0]  OPT_RC_OSC     = 8'h01;
    localparam logic [7:0]  OPT_BLANK      = 8'hff;
    localparam logic [7:0]  RF_GP_LAST     = 8'haf;
    localparam logic [7:0]  RF_PAGED_LAST  = 8'hbf;
    localparam logic [7:0]  RF_COMMON_BASE = 8'hc0;
    localparam logic [7:0]  RF_COMMON_LAST = 8'hcf;
    localparam logic [7:0]  RF_CTRL_BASE   = 8'hc0;
    localparam int          GP_P0_BYTES    = 176;
    localparam int          GP_P1_BYTES    = 192;
    localparam int          CTRL_BYTES     = 64;
    localparam logic [7:0]  UNDEF_READ     = 8'hff;
    typedef enum logic [1:0] {
        ASR_FETCH_SEQ,
        ASR_FETCH_VEC,
        ASR_FETCH_DATA
    } asr_fetch_kind_t;
    typedef enum logic [1:0] {
        ASR_RG_GP,
        ASR_RG_COMMON,
        ASR_RG_CTRL
    } asr_region_t;
endpackage

// ===== src/asr_decode.sv
// Register address decoder: classifies an 8-bit register address.
// Assumes page select and working-register mode come from the core.
`timescale 1ns/1ps
`default_nettype none
module asr_decode
    import asr_pkg::*;
(
    input  wire logic [7:0]  addr,
    input  wire logic        page1,
    output asr_region_t      region,
    output logic             impl,
    output logic [8:0]       gp_index,
    output logic [5:0]       ctrl_index
);
    // Page 1 spans 00h..BFh; page 0 GP ends at AFh
    wire page1_gp = page1 && (addr <= RF_PAGED_LAST);
    wire page0_gp = !page1 && (addr <= RF_GP_LAST);
    wire in_ctrl  = (addr >= RF_CTRL_BASE);
    assign region = in_ctrl ? ((addr <= RF_COMMON_LAST) ? ASR_RG_COMMON
                                                       : ASR_RG_CTRL)
                            : ASR_RG_GP;
    assign impl = page0_gp || page1_gp || in_ctrl;
    assign gp_index = page1_gp ? 9'(GP_P0_BYTES) + {1'b0, addr}
                               : {1'b0, addr};
    assign ctrl_index = 6'(addr - RF_CTRL_BASE);
endmodule
`default_nettype wire

// ===== verification/asr_rom_model.sv
// Program memory model facing the fetch side of the address-space block.
// Assumes a combinational read answering pm_addr in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module asr_rom_model
    import asr_pkg::*;
(
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  opt_byte,
    output logic      [7:0]  rdata
);
    logic in_range;
    logic opt_blank;
    assign in_range  = (addr <= PM_LAST);
    assign opt_blank = (addr >= PM_OPT_FIRST) && (addr < PM_OPT_USED);
    // Beyond the array the bus floats; an inverted pattern keeps it honest
    assign rdata = !in_range ? ~addr[7:0] :
                   (addr == PM_OPT_USED) ? opt_byte :
                   opt_blank ? OPT_BLANK :
                   addr[7:0] ^ addr[15:8];
endmodule
`default_nettype wire

// ===== verification/asr_space_tb.sv
// Self-checking bench for the address-space block with a program memory model.
// Assumes a single 100 MHz clock and inputs driven on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module asr_space_tb;
    import asr_pkg::*;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic        pc_step = 0, pc_load = 0, irq_take = 0, data_rd = 0;
    logic [15:0] pc_target = 0, data_addr = 0, pm_addr, rf_wdata = 0;
    logic        pm_valid, pm_vec, rc_osc_sel, opt_valid;
    logic [7:0]  pm_rdata, opt_v = 8'h01, rf_addr = 0;
    logic        rf_req = 0, rf_we = 0, rf_pair = 0, rf_wr_mode = 0, page1 = 0;
    logic [3:0]  rf_wreg = 0;
    logic [15:0] rf_rdata, t, w;
    logic        rf_ack, rf_bad_mode;
    logic [31:0] seed = 32'hdae5;
    logic [7:0]  a, b, v0, v1;
    logic [7:0]  opts [3] = '{8'h01, 8'hff, 8'h02};
    int          mismatches = 0;
    int          comparisons = 0;

    always #5 mclk = ~mclk;

    asr_space asr_space_i (.mclk(mclk), .rstn(rstn), .pc_step(pc_step),
        .pc_load(pc_load), .pc_target(pc_target), .irq_take(irq_take),
        .data_rd(data_rd), .data_addr(data_addr), .pm_addr(pm_addr),
        .pm_valid(pm_valid), .pm_vec(pm_vec), .pm_rdata(pm_rdata),
        .rc_osc_sel(rc_osc_sel), .opt_valid(opt_valid), .rf_req(rf_req),
        .rf_we(rf_we), .rf_pair(rf_pair), .rf_wr_mode(rf_wr_mode),
        .rf_wreg(rf_wreg), .rf_addr(rf_addr), .rf_wdata(rf_wdata),
        .page1(page1), .rf_rdata(rf_rdata), .rf_ack(rf_ack),
        .rf_bad_mode(rf_bad_mode));
    asr_rom_model asr_rom_model_i (.addr(pm_addr), .opt_byte(opt_v),
        .rdata(pm_rdata));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // One fetch request, checked on the cycle its answer stands
    task automatic fet(input logic st, input logic ld, input logic ir,
                       input logic dr, input logic [15:0] ad,
                       input logic [15:0] ex, input logic exv);
        pc_step = st; pc_load = ld; irq_take = ir; data_rd = dr;
        pc_target = ad; data_addr = ad;
        @(negedge mclk);
        pc_step = 0; pc_load = 0; irq_take = 0; data_rd = 0;
        chk(pm_valid, 1'b1);
        chk(pm_addr, ex);
        chk(pm_vec, exv);
        @(negedge mclk);
    endtask

    // One register access; mask picks the read bytes worth comparing
    task automatic rf(input logic we, input logic pr, input logic wm,
                      input logic pg, input logic [7:0] ad,
                      input logic [15:0] wd, input logic [15:0] ex,
                      input logic [15:0] mk, input logic bad);
        rf_req = 1; rf_we = we; rf_pair = pr; rf_wr_mode = wm; page1 = pg;
        rf_addr = ad; rf_wreg = ad[3:0]; rf_wdata = wd;
        @(negedge mclk);
        rf_req = 0;
        chk(rf_ack, 1'b1);
        chk(rf_bad_mode, bad);
        if (!we)
            chk(rf_rdata & mk, ex & mk);
        @(negedge mclk);
    endtask

    task automatic do_reset(input logic [7:0] ov);
        opt_v = ov;
        rstn = 0;
        repeat (16) @(negedge mclk);
        chk(pm_addr, PM_OPT_USED);
        chk({pm_valid, pm_vec, opt_valid, rc_osc_sel}, 16'h0000);
        chk({rf_ack, rf_bad_mode}, 16'h0000);
        chk(rf_rdata, 16'h0000);
        rstn = 1;
        @(negedge mclk);
        chk(pm_valid, 1'b1);
        chk(pm_addr, PM_OPT_USED);
        @(negedge mclk);
        chk(opt_valid, 1'b1);
        chk(rc_osc_sel, ov == OPT_RC_OSC);
    endtask

    initial begin
        for (int r = 0; r < 3; r++) begin
            do_reset(opts[r]);
            fet(1, 0, 0, 0, 16'h0000, PM_RESET_PC, 0);
            fet(1, 0, 0, 0, 16'h0000, PM_RESET_PC + 16'h0001, 0);
            t = xs() & 16'h3fff;
            fet(0, 1, 0, 0, t, PM_RESET_PC + 16'h0002, 0);
            fet(1, 0, 0, 0, 16'h0000, t, 0);
            fet(1, 0, 1, 0, 16'h0000, PM_VEC_LO, 1);
            chk({pm_valid, pm_vec}, 16'h0003);
            chk(pm_addr, PM_VEC_HI);
            fet(0, 0, 0, 1, PM_LAST, PM_LAST, 0);
            for (int i = 0; i < 8; i++) begin
                t = xs() & 16'h3fff;
                fet(1, 0, 0, 1, t, t, 0);
            end
        end
        for (int i = 0; i < 10; i++) begin
            a = xs() % GP_P0_BYTES;
            v0 = xs();
            v1 = xs();
            rf(1, 0, 0, 0, a, {8'h00, v0}, 0, 0, 0);
            rf(1, 0, 0, 1, a, {8'h00, v1}, 0, 0, 0);
            rf(0, 0, 0, 0, a, 0, v0, 16'h00ff, 0);
            rf(0, 0, 0, 1, a, 0, v1, 16'h00ff, 0);
            b = 8'hb0 | (xs() & 8'h0f);
            rf(1, 0, 0, 1, b, {8'h00, v0}, 0, 0, 0);
            rf(1, 0, 0, 0, b, {8'h00, v1}, 0, 0, 0);
            rf(0, 0, 0, 0, b, 0, UNDEF_READ, 16'h00ff, 0);
            rf(0, 0, 0, 1, b, 0, v0, 16'h00ff, 0);
            b = RF_COMMON_BASE | (xs() & 8'h0f);
            rf(1, 0, 1, 0, b, {8'h00, v1}, 0, 0, 0);
            rf(0, 0, 1, 1, b, 0, v1, 16'h00ff, 0);
            rf(0, 0, 0, 1, b, 0, v1, 16'h00ff, 1);
            a = (xs() % (GP_P0_BYTES / 2)) * 2;
            w = xs();
            rf(1, 1, 0, 0, a, w, 0, 0, 0);
            rf(0, 0, 0, 0, a, 0, w >> 8, 16'h00ff, 0);
            rf(0, 0, 0, 0, a | 8'h01, 0, w, 16'h00ff, 0);
            rf(0, 1, 0, 0, a | 8'h01, 0, w, 16'hffff, 0);
        end
        tally_and_finish();
    end

    // Run is about 440 cycles; this leaves a wide margin
    initial begin
        #100000;
        mismatches++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
